//--- sar_adc_sequencer.sv
// Sequencer, prescaler, sample timer and APB register file of the 8-channel SAR converter.
`timescale 1ns/100ps
`default_nettype none

module sar_adc_sequencer (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic stop_req,
  input wire logic wait_req,
  input wire logic comparator_high,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq,
  output logic digital_clk_en,
  output logic sh_clk_en,
  output logic sar_clk_en,
  output logic sample_cap_connect,
  output logic buffer_amp_en,
  output logic direct_connect,
  output logic [2:0] sample_channel,
  output logic special_ref_active,
  output logic [1:0] special_ref_sel,
  output logic [9:0] dac_code,
  output logic result_load
);

  logic [sar_pkg::POW_WIDTH-1:0] power_r;
  logic [sar_pkg::OPT_WIDTH-1:0] option_r;
  logic [sar_pkg::SA_WIDTH-1:0] setup_a_r;
  logic [sar_pkg::SB_WIDTH-1:0] setup_b_r;
  logic [15:0] result_r [8];
  logic [7:0] ccf_r;
  logic [7:0] ccf_nxt;
  logic scf_r;
  logic scf_nxt;
  sar_pkg::seq_state_t state_r;
  sar_pkg::seq_state_t state_nxt;
  logic [4:0] ph_r;
  logic [4:0] ph_nxt;
  logic [2:0] idx_r;
  logic [2:0] idx_nxt;
  logic [9:0] sar_r;
  logic [9:0] sar_nxt;
  logic [4:0] prs_cnt_r;
  logic prs_half_r;
  logic load;
  logic [31:0] rd_data;

  // Bus decode.
  // Every transfer gets exactly one wait-free access cycle, so pready is never stretched.
  wire setup_phase = psel & ~penable;
  wire access_phase = psel & penable & pready;
  wire aligned = (paddr[1:0] == 2'b00);
  wire hit_power = aligned & (paddr == sar_pkg::OFF_POWER);
  wire hit_option = aligned & (paddr == sar_pkg::OFF_OPTION);
  wire hit_setup_a = aligned & (paddr == sar_pkg::OFF_SETUP_A);
  wire hit_setup_b = aligned & (paddr == sar_pkg::OFF_SETUP_B);
  wire hit_status = aligned & (paddr == sar_pkg::OFF_STATUS);
  wire hit_result = aligned & (paddr[7:5] == sar_pkg::RESULT_BLOCK);
  wire hit_any = hit_power | hit_option | hit_setup_a | hit_setup_b | hit_status | hit_result;
  wire wr = access_phase & pwrite & hit_any;
  wire wr_status = wr & hit_status;

  // Control fields.
  wire power_up = power_r[sar_pkg::POW_UP_BIT];
  wire wait_sd = power_r[sar_pkg::POW_WAIT_SD_BIT];
  wire irq_en = power_r[sar_pkg::POW_IRQ_EN_BIT];
  wire [4:0] prescale = setup_a_r[4:0];
  wire [1:0] smp_sel = setup_a_r[sar_pkg::SA_SMP_LSB+1:sar_pkg::SA_SMP_LSB];
  wire res10 = setup_a_r[sar_pkg::SA_RES10_BIT];
  wire [2:0] chan_field = setup_b_r[2:0];
  wire special = setup_b_r[sar_pkg::SB_SPECIAL_BIT];
  wire multi = setup_b_r[sar_pkg::SB_MULTI_BIT];
  wire cont = setup_b_r[sar_pkg::SB_CONT_BIT];
  wire rjust = setup_b_r[sar_pkg::SB_RJUST_BIT];

  // Stop and wait act as levels, so the converter stays down for as long as stop lasts, or wait while wait_sd is set.
  // power down sources
  wire pd = ~power_up | stop_req | (wait_req & wait_sd);
  // A setup write while down only clears the flags, because power down wins below.
  // restart on setup write
  wire start = wr & (hit_setup_a | hit_setup_b);

  // Both length codes with the upper bit set select eight conversions.
  // sequence length
  wire [2:0] last_idx = (option_r == sar_pkg::LEN_FOUR) ? sar_pkg::LAST_IDX_FOUR :
                        (option_r == sar_pkg::LEN_ONE) ? sar_pkg::LAST_IDX_ONE : sar_pkg::LAST_IDX_EIGHT;
  wire [4:0] p3_len = sar_pkg::PHASE3_BASE_CLKS << smp_sel;
  wire [4:0] conv_len = res10 ? sar_pkg::CONV10_CLKS : sar_pkg::CONV8_CLKS;
  wire [4:0] nbits = res10 ? sar_pkg::BITS10 : sar_pkg::BITS8;
  // Both bit indexes wrap late in the phase; the guards in the state machine keep them unused there.
  wire [3:0] trial_bit = 4'h9 - ph_r[3:0];
  wire [3:0] resolve_bit = 4'hA - ph_r[3:0];

  // One module clock lasts 2*(P+1) pclk cycles, with P the five-bit prescale field.
  // prescaler then divide by two
  wire prs_wrap = (prs_cnt_r == prescale);
  wire mtick = ~pd & prs_wrap & prs_half_r;

  // Channel stepping wraps within the eight inputs, so a high start channel folds back to zero.
  // channel stepping
  wire [2:0] cur_ch = (multi & ~special) ? 3'(chan_field + idx_r) : chan_field;
  // Channel bit 1 picks the midpoint; otherwise bit 0 picks the high reference over the low one.
  // reference choice
  wire [1:0] ref_sel = chan_field[1] ? sar_pkg::REF_MID : (chan_field[0] ? sar_pkg::REF_HIGH : sar_pkg::REF_LOW);

  // At 8 bits the two lowest approximation bits are never tried and are dropped here.
  // justification
  wire [15:0] res_fmt = res10 ? (rjust ? {6'h00, sar_r} : {sar_r, 6'h00}) :
                        (rjust ? {8'h00, sar_r[9:2]} : {sar_r[9:2], 8'h00});

  // Status word and read mux.
  // The index field names the result slot that the next load will fill.
  // Unmapped addresses read zero; pslverr flags them and a write to them is dropped.
  wire busy = (state_r != sar_pkg::ST_IDLE);
  wire [31:0] status_word = {16'h0000, ccf_r, 1'b0, idx_r, 2'b00, busy, scf_r};
  assign rd_data = hit_power ? {29'h0, power_r} :
                   hit_option ? {30'h0, option_r} :
                   hit_setup_a ? {24'h0, setup_a_r} :
                   hit_setup_b ? {25'h0, setup_b_r} :
                   hit_status ? status_word :
                   hit_result ? {16'h0000, result_r[paddr[4:2]]} : 32'h0000_0000;

  always_comb begin
    state_nxt = state_r;
    ph_nxt = ph_r;
    idx_nxt = idx_r;
    sar_nxt = sar_r;
    load = 1'b0;
    if (pd) begin
      state_nxt = sar_pkg::ST_IDLE;
      ph_nxt = 5'h00;
      idx_nxt = 3'h0;
    end else if (start) begin
      state_nxt = sar_pkg::ST_SAMP1;
      ph_nxt = 5'h00;
      idx_nxt = 3'h0;
      sar_nxt = 10'h000;
    end else if (mtick) begin
      case (state_r)
        sar_pkg::ST_IDLE: begin
          state_nxt = sar_pkg::ST_IDLE;
        end
        sar_pkg::ST_SAMP1: begin
          if (ph_r == sar_pkg::PHASE1_CLKS - 5'h01) begin
            state_nxt = sar_pkg::ST_SAMP2;
            ph_nxt = 5'h00;
          end else begin
            ph_nxt = ph_r + 5'h01;
          end
        end
        sar_pkg::ST_SAMP2: begin
          if (ph_r == sar_pkg::PHASE2_CLKS - 5'h01) begin
            state_nxt = sar_pkg::ST_SAMP3;
            ph_nxt = 5'h00;
          end else begin
            ph_nxt = ph_r + 5'h01;
          end
        end
        sar_pkg::ST_SAMP3: begin
          if (ph_r == p3_len - 5'h01) begin
            state_nxt = sar_pkg::ST_CONV;
            ph_nxt = 5'h00;
            sar_nxt = 10'h000;
          end else begin
            ph_nxt = ph_r + 5'h01;
          end
        end
        sar_pkg::ST_CONV: begin
          // Each trial bit is judged one module clock after it is driven, so the array has a tick to settle.
          // resolve then trial
          if ((ph_r != 5'h00) && (ph_r <= nbits) && !comparator_high) begin
            sar_nxt[resolve_bit] = 1'b0;
          end
          if (ph_r < nbits) begin
            sar_nxt[trial_bit] = 1'b1;
          end
          if (ph_r == conv_len - 5'h01) begin
            load = 1'b1;
            ph_nxt = 5'h00;
            if (idx_r == last_idx) begin
              idx_nxt = 3'h0;
              state_nxt = cont ? sar_pkg::ST_SAMP1 : sar_pkg::ST_IDLE;
            end else begin
              idx_nxt = idx_r + 3'h1;
              state_nxt = sar_pkg::ST_SAMP1;
            end
          end else begin
            ph_nxt = ph_r + 5'h01;
          end
        end
        default: begin
          state_nxt = sar_pkg::ST_IDLE;
        end
      endcase
    end
  end

  // A sequence ends at the load of its last slot; a continuous run re-enters sampling on that tick.
  wire seq_end = load & (idx_r == last_idx);

  // cleared by setup write
  // A set in the same cycle as a write-one clear survives, so no completion is lost.
  assign ccf_nxt = start ? 8'h00 :
                   ((ccf_r & ~(wr_status ? pwdata[sar_pkg::ST_CCF_LSB+7:sar_pkg::ST_CCF_LSB] : 8'h00)) |
                    (load ? (8'h01 << idx_r) : 8'h00));
  assign scf_nxt = start ? 1'b0 :
                   ((scf_r & ~(wr_status & pwdata[sar_pkg::ST_SEQ_DONE_BIT])) | seq_end);

  // Bus answer: data is captured in the setup cycle and pready rises for exactly the access cycle.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      prdata <= setup_phase ? rd_data : 32'h0000_0000;
      pready <= setup_phase;
      pslverr <= setup_phase & ~hit_any;
    end
  end

  // Power and option writes act at once; only the two setup registers restart a sequence.
  // power bit resets low
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      power_r <= sar_pkg::POW_RESET;
      option_r <= sar_pkg::OPT_RESET;
      setup_a_r <= sar_pkg::SA_RESET;
      setup_b_r <= sar_pkg::SB_RESET;
    end else if (wr) begin
      if (hit_power) power_r <= pwdata[sar_pkg::POW_WIDTH-1:0];
      if (hit_option) option_r <= pwdata[sar_pkg::OPT_WIDTH-1:0];
      if (hit_setup_a) setup_a_r <= pwdata[sar_pkg::SA_WIDTH-1:0];
      if (hit_setup_b) setup_b_r <= pwdata[sar_pkg::SB_WIDTH-1:0];
    end
  end

  // Result words are not reset; software only trusts one whose flag is set.
  // transfer into result
  always_ff @(posedge pclk) begin
    if (load) result_r[idx_r] <= res_fmt;
  end

  // A restart realigns the module clock, so the first sample phase of a new sequence is full length.
  // modulus counter
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prs_cnt_r <= 5'h00;
      prs_half_r <= 1'b0;
    end else if (pd) begin
      prs_cnt_r <= 5'h00;
      prs_half_r <= 1'b0;
    end else if (start) begin
      prs_cnt_r <= 5'h00;
      prs_half_r <= 1'b0;
    end else if (prs_wrap) begin
      prs_cnt_r <= 5'h00;
      prs_half_r <= ~prs_half_r;
    end else begin
      prs_cnt_r <= prs_cnt_r + 5'h01;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_r <= sar_pkg::ST_IDLE;
      ph_r <= 5'h00;
      idx_r <= 3'h0;
      sar_r <= 10'h000;
      ccf_r <= 8'h00;
      scf_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      ph_r <= ph_nxt;
      idx_r <= idx_nxt;
      sar_r <= sar_nxt;
      ccf_r <= ccf_nxt;
      scf_r <= scf_nxt;
    end
  end

  // Phase enables and dac_code follow the next state so they line up with it on the same edge; sample_channel follows the current index.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
      digital_clk_en <= 1'b0;
      sh_clk_en <= 1'b0;
      sar_clk_en <= 1'b0;
      sample_cap_connect <= 1'b0;
      buffer_amp_en <= 1'b0;
      direct_connect <= 1'b0;
      sample_channel <= 3'h0;
      special_ref_active <= 1'b0;
      special_ref_sel <= 2'h0;
      dac_code <= 10'h000;
      result_load <= 1'b0;
    end else begin
      irq <= irq_en & scf_nxt;
      digital_clk_en <= ~pd;
      sh_clk_en <= (state_nxt == sar_pkg::ST_SAMP1) | (state_nxt == sar_pkg::ST_SAMP2) |
                   (state_nxt == sar_pkg::ST_SAMP3);
      sar_clk_en <= (state_nxt == sar_pkg::ST_CONV);
      sample_cap_connect <= (state_nxt == sar_pkg::ST_SAMP1);
      buffer_amp_en <= (state_nxt == sar_pkg::ST_SAMP2);
      direct_connect <= (state_nxt == sar_pkg::ST_SAMP3);
      sample_channel <= cur_ch;
      special_ref_active <= special;
      special_ref_sel <= ref_sel;
      // The trial bit reaches the array in the same clock that sets it.
      dac_code <= sar_nxt;
      result_load <= load;
    end
  end

endmodule // sar_adc_sequencer

`default_nettype wire

//--- sar_pkg.sv
// Constants, register map and state type for the successive-approximation converter sequencer.
package sar_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] OFF_POWER = 8'h00;
  localparam logic [7:0] OFF_OPTION = 8'h04;
  localparam logic [7:0] OFF_SETUP_A = 8'h08;
  localparam logic [7:0] OFF_SETUP_B = 8'h0C;
  localparam logic [7:0] OFF_STATUS = 8'h10;
  localparam logic [2:0] RESULT_BLOCK = 3'h1;

  // Power control register fields.
  localparam int POW_UP_BIT = 0;
  localparam int POW_WAIT_SD_BIT = 1;
  localparam int POW_IRQ_EN_BIT = 2;
  localparam int POW_WIDTH = 3;
  localparam logic [2:0] POW_RESET = 3'h0;

  // Sequence option register: length select, 00 four, 01 one, 1x eight.
  localparam int OPT_WIDTH = 2;
  localparam logic [1:0] OPT_RESET = 2'h0;
  localparam logic [1:0] LEN_FOUR = 2'h0;
  localparam logic [1:0] LEN_ONE = 2'h1;
  localparam logic [2:0] LAST_IDX_FOUR = 3'h3;
  localparam logic [2:0] LAST_IDX_ONE = 3'h0;
  localparam logic [2:0] LAST_IDX_EIGHT = 3'h7;

  // Setup register A: prescaler [4:0], sample time [6:5], 10-bit resolution [7].
  localparam int SA_SMP_LSB = 5;
  localparam int SA_RES10_BIT = 7;
  localparam int SA_WIDTH = 8;
  localparam logic [7:0] SA_RESET = 8'h00;

  // Setup register B: channel [2:0], special [3], multi [4], continuous [5], right justify [6].
  localparam int SB_SPECIAL_BIT = 3;
  localparam int SB_MULTI_BIT = 4;
  localparam int SB_CONT_BIT = 5;
  localparam int SB_RJUST_BIT = 6;
  localparam int SB_WIDTH = 7;
  localparam logic [6:0] SB_RESET = 7'h00;

  // Status register fields.
  localparam int ST_SEQ_DONE_BIT = 0;
  localparam int ST_BUSY_BIT = 1;
  localparam int ST_IDX_LSB = 4;
  localparam int ST_CCF_LSB = 8;

  // Sample and conversion lengths in module clocks.
  localparam logic [4:0] PHASE1_CLKS = 5'h02;
  localparam logic [4:0] PHASE2_CLKS = 5'h04;
  localparam logic [4:0] PHASE3_BASE_CLKS = 5'h02;
  localparam logic [4:0] CONV8_CLKS = 5'h0A;
  localparam logic [4:0] CONV10_CLKS = 5'h0C;
  localparam logic [4:0] BITS8 = 5'h08;
  localparam logic [4:0] BITS10 = 5'h0A;

  // Special reference selection driven to the analog side.
  localparam logic [1:0] REF_LOW = 2'h0;
  localparam logic [1:0] REF_HIGH = 2'h1;
  localparam logic [1:0] REF_MID = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_SAMP1,
    ST_SAMP2,
    ST_SAMP3,
    ST_CONV
  } seq_state_t;

endpackage

//--- sar_adc_sequencer_props.sv
// Port-level assertions for the converter sequencer, bound to its top module.
`timescale 1ns/100ps
`default_nettype none
module sar_adc_sequencer_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic stop_req,
  input wire logic wait_req,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic irq,
  input wire logic digital_clk_en,
  input wire logic sh_clk_en,
  input wire logic sar_clk_en,
  input wire logic sample_cap_connect,
  input wire logic buffer_amp_en,
  input wire logic direct_connect,
  input wire logic [2:0] sample_channel,
  input wire logic result_load
);
  logic [2:0] pwr_r;
  logic [7:0] sa_r;
  logic [6:0] sb_r;
  logic [7:0] c1_r, c2_r, c3_r, cc_r;
  logic sar_q_r;
  logic [1:0] quiet_r;
  int tick;
  wire logic wr_ok = psel && penable && pready && pwrite && !pslverr;
  wire logic setup_wr = wr_ok && (paddr == sar_pkg::OFF_SETUP_A || paddr == sar_pkg::OFF_SETUP_B);
  assign tick = 2 * (int'(sa_r[4:0]) + 1);
  // Phase lengths are counted in pclk; the conversion count is held until the result shows.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pwr_r <= 3'h0;
      sa_r <= 8'h00;
      sb_r <= 7'h00;
      c1_r <= 8'h00;
      c2_r <= 8'h00;
      c3_r <= 8'h00;
      cc_r <= 8'h00;
      sar_q_r <= 1'b0;
      quiet_r <= 2'h0;
    end else begin
      if (wr_ok && paddr == sar_pkg::OFF_POWER) pwr_r <= pwdata[2:0];
      if (wr_ok && paddr == sar_pkg::OFF_SETUP_A) sa_r <= pwdata[7:0];
      if (wr_ok && paddr == sar_pkg::OFF_SETUP_B) sb_r <= pwdata[6:0];
      c1_r <= (sample_cap_connect && !setup_wr) ? c1_r + 8'h01 : 8'h00;
      c2_r <= buffer_amp_en ? c2_r + 8'h01 : 8'h00;
      c3_r <= direct_connect ? c3_r + 8'h01 : 8'h00;
      cc_r <= sar_clk_en ? (sar_q_r ? cc_r + 8'h01 : 8'h01) : cc_r;
      sar_q_r <= sar_clk_en;
      quiet_r <= {quiet_r[0], setup_wr};
    end
  end
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  AST_PREADY_NEXT: assert property (psel && !penable |=> pready)
    else $error("pready missing after setup");
  AST_BAD_ADDR_ERR: assert property (psel && !penable && paddr[1:0] != 2'h0 |=> pslverr)
    else $error("unaligned access not refused");
  AST_POWER_DOWN: assert property ((stop_req || !pwr_r[0] || (wait_req && pwr_r[1]))[*3]
    |-> !digital_clk_en && !sh_clk_en && !sar_clk_en) else $error("converter not powered down");
  AST_PHASE1_LEN: assert property ($fell(sample_cap_connect) && buffer_amp_en |-> c1_r == 2 * tick)
    else $error("first sample phase length wrong");
  AST_PHASE2_LEN: assert property ($fell(buffer_amp_en) && direct_connect |-> c2_r == 4 * tick)
    else $error("second sample phase length wrong");
  AST_PHASE3_LEN: assert property ($fell(direct_connect) && sar_clk_en |-> c3_r == (2 << sa_r[6:5]) * tick)
    else $error("third sample phase length wrong");
  AST_CONV_LEN: assert property ($rose(result_load) |-> cc_r == (sa_r[7] ? 12 : 10) * tick)
    else $error("approximation length wrong");
  AST_SETUP_CLEARS_IRQ: assert property (setup_wr |-> ##2 !irq)
    else $error("interrupt survived a setup write");
  AST_SH_GATE: assert property (sh_clk_en == (sample_cap_connect || buffer_amp_en || direct_connect)
    && !(sh_clk_en && sar_clk_en)) else $error("sub-unit clock gating wrong");
  AST_SINGLE_CHANNEL: assert property (sample_cap_connect && !sb_r[4] && !sb_r[3] && quiet_r == 2'h0
    |-> sample_channel == sb_r[2:0]) else $error("single-channel sequence on wrong channel");
  COV_RESULT: cover property ($rose(result_load));
  COV_REFUSED: cover property (pready && pslverr);
  COV_STOP: cover property (stop_req && !digital_clk_en);
endmodule // sar_adc_sequencer_props

bind sar_adc_sequencer sar_adc_sequencer_props u_props (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .stop_req(stop_req),
  .wait_req(wait_req), .pready(pready), .pslverr(pslverr), .irq(irq), .digital_clk_en(digital_clk_en),
  .sh_clk_en(sh_clk_en), .sar_clk_en(sar_clk_en), .sample_cap_connect(sample_cap_connect),
  .buffer_amp_en(buffer_amp_en), .direct_connect(direct_connect), .sample_channel(sample_channel),
  .result_load(result_load));
`default_nettype wire

//--- sar_analog_model.sv
// Behavioural comparator and reference source facing the converter.
`timescale 1ns/100ps
`default_nettype none
module sar_analog_model (
  input wire logic pclk,
  input wire logic sar_clk_en,
  input wire logic special_ref_active,
  input wire logic [1:0] special_ref_sel,
  input wire logic [2:0] sample_channel,
  input wire logic [9:0] dac_code,
  input wire logic [9:0] level,
  output logic comparator_high
);
  logic junk_r = 1'b0;
  logic [9:0] held;
  // Outside an approximation the comparator output means nothing, so it toggles every cycle.
  always_ff @(posedge pclk) begin
    junk_r <= ~junk_r;
  end
  assign held = !special_ref_active ? (level ^ {7'h00, sample_channel}) :
    special_ref_sel == sar_pkg::REF_HIGH ? 10'h3FF : special_ref_sel == sar_pkg::REF_MID ? 10'h200 : 10'h000;
  assign comparator_high = sar_clk_en ? (held >= dac_code) : junk_r;
endmodule // sar_analog_model
`default_nettype wire

//--- tb_sar_adc_sequencer.sv
// Self-checking bench for the converter sequencer over its APB port.
`timescale 1ns/100ps
`default_nettype none
module tb_sar_adc_sequencer;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0000_0000;
  logic stop_req = 1'b0;
  logic wait_req = 1'b0;
  logic [9:0] level = 10'h2B0;
  wire logic [31:0] prdata;
  wire logic [9:0] dac_code;
  wire logic [2:0] sample_channel;
  wire logic [1:0] special_ref_sel;
  wire logic comparator_high, pready, pslverr, irq, digital_clk_en, sar_clk_en, special_ref_active;
  int errors = 0;
  int total_checks = 0;
  logic [31:0] rd;
  always #25 pclk = ~pclk;
  sar_adc_sequencer DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .stop_req(stop_req), .wait_req(wait_req), .comparator_high(comparator_high),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .digital_clk_en(digital_clk_en),
    .sh_clk_en(), .sar_clk_en(sar_clk_en), .sample_cap_connect(), .buffer_amp_en(), .direct_connect(),
    .sample_channel(sample_channel), .special_ref_active(special_ref_active),
    .special_ref_sel(special_ref_sel), .dac_code(dac_code), .result_load());
  sar_analog_model u_analog (.pclk(pclk), .sar_clk_en(sar_clk_en), .special_ref_active(special_ref_active),
    .special_ref_sel(special_ref_sel), .sample_channel(sample_channel), .dac_code(dac_code), .level(level),
    .comparator_high(comparator_high));
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  // One transfer; read data and the error flag are taken at the edge where pready is seen.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // Only the watchdog ends a transfer that the slave never answers.
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = {prdata[31:1], prdata[0]};
    if (pslverr === 1'b1) rd = 32'hEEEE_EEEE;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask
  task automatic wait_done();
    int n;
    n = 0;
    rd = 32'h0000_0000;
    while (rd[0] !== 1'b1 && n < 2000) begin
      apb(1'b0, sar_pkg::OFF_STATUS, 32'h0000_0000);
      n++;
    end
    // A sequence that never completes counts as a mismatch.
    if (rd[0] !== 1'b1) errors++;
  endtask
  function automatic logic [31:0] fmt(input logic [9:0] v, input logic r10, input logic rj);
    logic [15:0] w;
    w = r10 ? (rj ? {6'h00, v} : {v, 6'h00}) : (rj ? {8'h00, v[9:2]} : {v[9:2], 8'h00});
    return {16'h0000, w};
  endfunction
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  initial begin
    repeat (40000) @(posedge pclk);
    errors++;
    final_report();
  end
  initial begin
    int n;
    logic r10, rj, sp;
    logic [2:0] ch;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rdchk(sar_pkg::OFF_POWER, 32'h0000_0000);
    check(32'(digital_clk_en), 32'h0000_0000);
    rdchk(sar_pkg::OFF_SETUP_B, 32'h0000_0000);
    rdchk(8'h14, 32'hEEEE_EEEE);
    rdchk(8'h02, 32'hEEEE_EEEE);
    $display("test reset done");
    apb(1'b1, sar_pkg::OFF_POWER, 32'h0000_0005);
    // Bias settling time before the first conversion.
    // bias settling wait
    repeat (20) @(posedge pclk);
    check(32'(digital_clk_en), 32'h0000_0001);
    for (int i = 0; i < 4; i++) begin
      n = (i == 1) ? 4 : (i == 2) ? 8 : 1;
      r10 = ~i[0];
      rj = i[0] ^ i[1];
      sp = (i == 3);
      apb(1'b1, sar_pkg::OFF_OPTION, (i == 1) ? 32'h0000_0000 : (i == 2) ? 32'h0000_0002 : 32'h0000_0001);
      apb(1'b1, sar_pkg::OFF_SETUP_A, {24'h00_0000, r10, 2'(i), 5'(i)});
      apb(1'b1, sar_pkg::OFF_SETUP_B, {25'h000_0000, rj, 1'b0, rj, sp, 3'h6});
      wait_done();
      check(32'(rd[15:8]), 32'((1 << n) - 1));
      check(32'(irq), 32'h0000_0001);
      if (sp) check(32'(special_ref_sel), 32'(sar_pkg::REF_MID));
      ch = rj ? 3'h6 + 3'(n - 1) : 3'h6;
      rdchk(8'h20 + 8'(4 * (n - 1)), fmt(sp ? 10'h200 : level ^ {7'h00, ch}, r10, rj));
      apb(1'b1, sar_pkg::OFF_STATUS, 32'h0000_0001);
      check(32'(irq), 32'h0000_0000);
    end
    $display("test sequences done");
    apb(1'b1, sar_pkg::OFF_SETUP_B, 32'h0000_0020);
    wait_done();
    apb(1'b1, sar_pkg::OFF_STATUS, 32'h0000_0001);
    wait_done();
    check(32'(rd[0]), 32'h0000_0001);
    apb(1'b1, sar_pkg::OFF_SETUP_B, 32'h0000_0000);
    rdchk(sar_pkg::OFF_STATUS, 32'h0000_0002);
    wait_done();
    apb(1'b1, sar_pkg::OFF_STATUS, 32'h0000_0001);
    repeat (100) @(posedge pclk);
    rdchk(sar_pkg::OFF_STATUS, 32'h0000_0100);
    $display("test continuous done");
    apb(1'b1, sar_pkg::OFF_SETUP_B, 32'h0000_0020);
    repeat (10) @(posedge pclk);
    stop_req <= 1'b1;
    repeat (4) @(posedge pclk);
    check(32'(digital_clk_en), 32'h0000_0000);
    rdchk(sar_pkg::OFF_SETUP_B, 32'h0000_0020);
    stop_req <= 1'b0;
    repeat (4) @(posedge pclk);
    apb(1'b0, sar_pkg::OFF_STATUS, 32'h0000_0000);
    check(32'(rd[1]), 32'h0000_0000);
    apb(1'b1, sar_pkg::OFF_POWER, 32'h0000_0003);
    wait_req <= 1'b1;
    repeat (4) @(posedge pclk);
    check(32'(digital_clk_en), 32'h0000_0000);
    wait_req <= 1'b0;
    apb(1'b1, sar_pkg::OFF_POWER, 32'h0000_0001);
    wait_req <= 1'b1;
    repeat (4) @(posedge pclk);
    check(32'(digital_clk_en), 32'h0000_0001);
    wait_req <= 1'b0;
    apb(1'b1, sar_pkg::OFF_POWER, 32'h0000_0000);
    // The clock gate follows the power bit one clock after the write lands.
    @(posedge pclk);
    check(32'(digital_clk_en), 32'h0000_0000);
    rdchk(sar_pkg::OFF_SETUP_A, 32'h0000_0063);
    $display("test power done");
    final_report();
  end
endmodule // tb_sar_adc_sequencer
`default_nettype wire
